// file: logic/ver_readout.sv
// Purpose: backplane slave that streams stored events to the bus master
// Assumes: bus signals arrive already decoded to a synchronous beat request
// Notes: the event writer supplies whole events, last word flagged
module ver_readout #(
    parameter int DEPTH = ver_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Event store side
    input wire ver_pkg::ver_word_t evt_in,
    input wire logic evt_in_valid,
    output logic evt_in_ready,
    output logic buf_free,
    output logic store_clear,
    // Front panel
    input wire logic ttr_n,
    input wire logic mclr_n,
    // Control
    input wire logic sw_clear,
    input wire logic berr_en,
    input wire logic even_word_padding_enable,
    input wire logic reloc_en,
    input wire logic [15:0] reloc_addr,
    input wire logic [7:0] blt_evt_num,
    input wire logic [15:0] block_size,
    input wire ver_pkg::ver_role_t cblt_role,
    input wire logic [7:0] cblt_base,
    // Straps
    input wire logic [15:0] rot_sw,
    input wire logic [4:0] geo,
    // Bus
    input wire logic bus_cyc,
    input wire logic bus_req,
    input wire logic [31:0] bus_addr,
    input wire logic [5:0] bus_am,
    input wire logic bus_blk,
    output logic bus_ack,
    output logic bus_err,
    output logic [31:0] bus_rdata,
    input wire logic iack_in,
    output logic iack_out,
    // Status
    output logic [31:0] time_tag,
    output logic [23:0] evt_cnt,
    output logic [19:0] evt_bytes,
    output logic err_latched,
    output logic [31:0] base_addr
);

    // ======================================================================
    // Declarations
    ver_pkg::ver_word_t fifo_out;
    logic fifo_valid;
    logic fifo_pop;
    logic mem_clr;
    logic [15:0] sw_base_ff;
    logic strap_done_ff;
    logic [15:0] base_hi;
    logic is_a24;
    logic is_a32;
    logic own_hit;
    logic chain_hit;
    logic cr_hit;
    logic tok_take;
    ver_pkg::ver_tok_t tok_ff;
    ver_pkg::ver_tok_t nxt_tok;
    logic cyc_d_ff;
    logic cyc_rise;
    logic cyc_fall;
    logic pend_ff;
    logic pend_chain_ff;
    logic pend_blk_ff;
    logic cr_pend_ff;
    logic mid_evt_ff;
    logic [7:0] cyc_evts_ff;
    logic [15:0] cyc_words_ff;
    logic limit_hit;
    logic stop;
    logic need_pad;
    logic do_pad;
    logic do_pass;
    logic do_err;
    logic do_fill;
    logic do_data;
    logic [31:0] time_tag_ff;
    logic [23:0] evt_cnt_ff;
    logic [19:0] evt_bytes_ff;
    logic err_ff;
    logic [31:0] base_addr_ff;
    logic ack_ff;
    logic err_out_ff;
    logic [31:0] rdata_ff;
    logic iack_ff;
    logic free_ff;
    logic clr_ff;

    // ======================================================================
    // Event buffer
    // Writer keeps filling while the bus drains; ready stalls it when full
    ver_fifo #(
        .WIDTH($bits(ver_pkg::ver_word_t)),
        .DEPTH(DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .clear(mem_clr),
        .in_data(evt_in),
        .in_valid(evt_in_valid),
        .in_ready(evt_in_ready),
        .out_data(fifo_out),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );

    // Front-panel inputs are active low while the clear acts
    assign mem_clr = sw_clear || !mclr_n;

    // ======================================================================
    // Base address
    // Switches are caught once after reset release, never while running
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sw_base_ff <= ver_pkg::BASE_RESET;
            strap_done_ff <= 1'b0;
        end else if (!strap_done_ff) begin
            sw_base_ff <= rot_sw;
            strap_done_ff <= 1'b1;
        end
    end

    assign base_hi = (reloc_en && reloc_addr != 16'h0000) ? reloc_addr : sw_base_ff;

    // ======================================================================
    // Address decode
    assign is_a24 = bus_am[5:4] == ver_pkg::AM_A24_CLASS;
    assign is_a32 = bus_am[5:4] == ver_pkg::AM_A32_CLASS && bus_am[3];
    // A24 uses only the low switch byte, so the top base is 0xFF0000
    assign own_hit = bus_addr[15:ver_pkg::WIN_LSB] == ver_pkg::WIN_PAGE
        && ((is_a24 && bus_addr[23:16] == base_hi[7:0])
        || (is_a32 && bus_addr[31:16] == base_hi));
    assign chain_hit = cblt_role != ver_pkg::ROLE_NONE && is_a32
        && bus_addr[31:24] == cblt_base
        && bus_addr[23:ver_pkg::WIN_LSB] == 12'h000;
    assign cr_hit = bus_am == ver_pkg::AM_CRCSR
        && bus_addr[23:ver_pkg::GEO_LSB] == geo;
    assign tok_take = cblt_role == ver_pkg::ROLE_FIRST
        && tok_ff == ver_pkg::TOK_IDLE && !mid_evt_ff;

    assign cyc_rise = bus_cyc && !cyc_d_ff;
    assign cyc_fall = !bus_cyc && cyc_d_ff;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cyc_d_ff <= 1'b0;
        end else begin
            cyc_d_ff <= bus_cyc;
        end
    end

    // ======================================================================
    // Pending beat
    // A beat waits here while an event is half delivered and data lags
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pend_ff <= 1'b0;
            pend_chain_ff <= 1'b0;
            pend_blk_ff <= 1'b0;
            cr_pend_ff <= 1'b0;
        end else if (cyc_fall) begin
            pend_ff <= 1'b0;
            cr_pend_ff <= 1'b0;
        end else if (bus_req) begin
            cr_pend_ff <= cr_hit;
            if (chain_hit && (tok_ff == ver_pkg::TOK_HOLD || tok_take)) begin
                pend_ff <= 1'b1;
                pend_chain_ff <= 1'b1;
                pend_blk_ff <= 1'b1;
            end else if (own_hit) begin
                pend_ff <= 1'b1;
                pend_chain_ff <= 1'b0;
                pend_blk_ff <= bus_blk;
            end
        end else begin
            cr_pend_ff <= 1'b0;
            if (do_data || do_pad || do_fill || do_err || do_pass) begin
                pend_ff <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Beat decision
    assign limit_hit = pend_blk_ff && blt_evt_num != 8'h00
        && cyc_evts_ff == blt_evt_num;
    assign stop = pend_ff && !mid_evt_ff
        && ((limit_hit && (berr_en || pend_chain_ff))
        || (!fifo_valid && (berr_en || pend_chain_ff)));
    assign need_pad = even_word_padding_enable && cyc_words_ff[0];
    assign do_pad = stop && need_pad;
    assign do_pass = stop && !need_pad && pend_chain_ff
        && cblt_role != ver_pkg::ROLE_LAST;
    assign do_err = stop && !need_pad && !do_pass;
    assign do_data = pend_ff && !stop && fifo_valid
        && !(limit_hit && !berr_en);
    assign do_fill = pend_ff && !stop && !mid_evt_ff
        && (!fifo_valid || limit_hit);
    assign fifo_pop = do_data && !mem_clr;

    // ======================================================================
    // Event progress
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mid_evt_ff <= 1'b0;
        end else if (mem_clr) begin
            mid_evt_ff <= 1'b0;
        end else if (fifo_pop) begin
            mid_evt_ff <= !fifo_out.last;
        end
    end

    // Per-cycle counts restart with each new bus cycle
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cyc_evts_ff <= 8'h00;
            cyc_words_ff <= 16'h0000;
        end else if (cyc_rise) begin
            cyc_evts_ff <= 8'h00;
            cyc_words_ff <= 16'h0000;
        end else begin
            if (fifo_pop && fifo_out.last) begin
                cyc_evts_ff <= cyc_evts_ff + 8'h01;
            end
            if (fifo_pop || do_pad) begin
                cyc_words_ff <= cyc_words_ff + 16'h0001;
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            evt_cnt_ff <= 24'h000000;
        end else if (fifo_pop && fifo_out.last) begin
            evt_cnt_ff <= evt_cnt_ff + 24'h000001;
        end
    end

    // ======================================================================
    // Token passing
    always_comb begin
        nxt_tok = tok_ff;
        case (tok_ff)
            ver_pkg::TOK_IDLE: begin
                if (bus_req && chain_hit && tok_take) begin
                    nxt_tok = ver_pkg::TOK_HOLD;
                end else if (iack_in && cblt_role != ver_pkg::ROLE_FIRST
                    && cblt_role != ver_pkg::ROLE_NONE) begin
                    nxt_tok = ver_pkg::TOK_HOLD;
                end
            end
            ver_pkg::TOK_HOLD: begin
                if (do_pass) begin
                    nxt_tok = ver_pkg::TOK_PASSED;
                end else if (cyc_fall && !mid_evt_ff) begin
                    nxt_tok = ver_pkg::TOK_IDLE;
                end
            end
            ver_pkg::TOK_PASSED: begin
                if (cyc_fall) begin
                    nxt_tok = ver_pkg::TOK_IDLE;
                end
            end
            default: begin
                nxt_tok = ver_pkg::TOK_IDLE;
            end
        endcase
    end

    // Held mid-event, the token survives the cycle end
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tok_ff <= ver_pkg::TOK_IDLE;
        end else begin
            tok_ff <= nxt_tok;
        end
    end

    // ======================================================================
    // Bus answer
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_ff <= 1'b0;
            err_out_ff <= 1'b0;
            iack_ff <= 1'b0;
            free_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= do_data || do_pad || do_fill || cr_pend_ff;
            err_out_ff <= do_err;
            iack_ff <= do_pass;
            free_ff <= fifo_pop && fifo_out.last;
            if (cr_pend_ff) begin
                rdata_ff <= {27'h0000000, geo};
            end else if (do_data) begin
                rdata_ff <= fifo_out.data;
            end else if (do_pad) begin
                rdata_ff <= ver_pkg::PAD_WORD;
            end else if (do_fill) begin
                rdata_ff <= ver_pkg::FILLER_WORD;
            end
        end
    end

    // ======================================================================
    // Timer and status
    // Held low restarts the tag every cycle; release lets it run
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            time_tag_ff <= 32'h0000_0000;
        end else if (!ttr_n) begin
            time_tag_ff <= 32'h0000_0000;
        end else begin
            time_tag_ff <= time_tag_ff + 32'h0000_0001;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            err_ff <= 1'b0;
            evt_bytes_ff <= ver_pkg::HDR_BYTES;
            base_addr_ff <= 32'h0000_0000;
            clr_ff <= 1'b0;
        end else begin
            if (do_err) begin
                err_ff <= 1'b1;
            end
            evt_bytes_ff <= (20'(block_size) << ver_pkg::BLK_BYTE_SHIFT)
                + ver_pkg::HDR_BYTES;
            base_addr_ff <= {base_hi, 16'h0000};
            clr_ff <= mem_clr;
        end
    end

    // ======================================================================
    // Outputs
    assign bus_ack = ack_ff;
    assign bus_err = err_out_ff;
    assign bus_rdata = rdata_ff;
    assign iack_out = iack_ff;
    assign buf_free = free_ff;
    assign store_clear = clr_ff;
    assign time_tag = time_tag_ff;
    assign evt_cnt = evt_cnt_ff;
    assign evt_bytes = evt_bytes_ff;
    assign err_latched = err_ff;
    assign base_addr = base_addr_ff;

endmodule

// file: logic/ver_pkg.sv
// Purpose: shared constants and types for the backplane event readout slave
// Assumes: one clock, core_clk at 100 MHz; synchronous inputs
// Notes: widths and counts that may differ are module parameters elsewhere
// ==========================================================================
// ==========================================================================
package ver_pkg;

    // ======================================================================
    // Address decode
    localparam logic [5:0] AM_CRCSR = 6'h2F;
    localparam logic [1:0] AM_A24_CLASS = 2'h3;
    localparam logic [1:0] AM_A32_CLASS = 2'h0;
    localparam int GEO_LSB = 19;
    localparam int WIN_LSB = 12;
    localparam logic [3:0] WIN_PAGE = 4'h0;
    localparam logic [15:0] BASE_RESET = 16'h0000;

    // ======================================================================
    // Data words and sizes
    localparam logic [31:0] FILLER_WORD = 32'hFFFF_FFFF;
    localparam logic [31:0] PAD_WORD = 32'h0000_0000;
    localparam logic [19:0] HDR_BYTES = 20'h00010;
    localparam int BLK_BYTE_SHIFT = 3;
    localparam int FIFO_DEPTH = 16;

    // ======================================================================
    // Types
    typedef enum logic [1:0] {
        ROLE_NONE,
        ROLE_FIRST,
        ROLE_MID,
        ROLE_LAST
    } ver_role_t;

    typedef enum logic [1:0] {
        TOK_IDLE,
        TOK_HOLD,
        TOK_PASSED
    } ver_tok_t;

    typedef struct packed {
        logic last;
        logic [31:0] data;
    } ver_word_t;

endpackage

// file: logic/ver_fifo.sv
// Purpose: word FIFO between the event store and the bus readout
// Assumes: one clock; clear empties it in one cycle
// Notes: depth must be a power of two
module ver_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clear,
    // Fill side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Drain side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_ff;
    logic [AW:0] rd_ptr_ff;
    logic do_wr;
    logic do_rd;

    // ======================================================================
    // Flags
    assign in_ready = (wr_ptr_ff - rd_ptr_ff) != (AW+1)'(DEPTH);
    assign out_valid = wr_ptr_ff != rd_ptr_ff;
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;
    assign out_data = mem[rd_ptr_ff[AW-1:0]];

    // ======================================================================
    // Storage
    always_ff @(posedge core_clk) begin
        if (do_wr) begin
            mem[wr_ptr_ff[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else if (clear) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
        end
    end

endmodule

// file: tb/ver_readout_asserts.sv
// Purpose: port checks for the readout slave
// Assumes: one clock, async active-high reset
// Notes: bound to every ver_readout
module ver_readout_asserts (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Inputs
    input wire logic ttr_n,
    input wire logic mclr_n,
    input wire logic sw_clear,
    input wire logic reloc_en,
    input wire logic [15:0] block_size,
    input wire logic [4:0] geo,
    input wire logic bus_req,
    input wire logic [31:0] bus_addr,
    input wire logic [5:0] bus_am,
    // Outputs
    input wire logic bus_ack,
    input wire logic bus_err,
    input wire logic [31:0] bus_rdata,
    input wire logic buf_free,
    input wire logic store_clear,
    input wire logic [31:0] time_tag,
    input wire logic [19:0] evt_bytes,
    input wire logic err_latched,
    input wire logic [31:0] base_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // ==================================================================
    // Config space beats
    sequence csr_s(logic hit);
        bus_req && bus_am == ver_pkg::AM_CRCSR && (bus_addr[23:19] == geo) == hit;
    endsequence
    sequence slot_s;
        ##2 bus_ack && bus_rdata == {27'h0, geo};
    endsequence
    csr_slot_a: assert property (
        csr_s(1'b1) |-> slot_s) else $error("slot read wrong");
    csr_miss_a: assert property (
        csr_s(1'b0) |-> ##2 !bus_ack && !bus_err)
        else $error("foreign slot answered");
    // ==================================================================
    // Answers and side effects
    ack_excl_a: assert property (!(bus_ack && bus_err))
        else $error("ack with error");
    free_ack_a: assert property (buf_free |-> bus_ack)
        else $error("free without read");
    clear_store_a: assert property (!mclr_n || sw_clear |=> store_clear)
        else $error("clear not passed on");
    tag_hold_a: assert property (!ttr_n [*2] |-> time_tag == 32'h0)
        else $error("tag not held");
    err_sticky_a: assert property (bus_err || err_latched |=> err_latched)
        else $error("error not latched");
    // Skips the edges where reset values are still visible
    evt_len_a: assert property (
        !$past(sys_rst) && $stable(block_size)
        |-> evt_bytes == {1'b0, block_size, 3'h0} + ver_pkg::HDR_BYTES)
        else $error("event length wrong");
    base_hold_a: assert property (
        !$past(sys_rst) && !$past(sys_rst, 2) && !$past(sys_rst, 3) && !reloc_en
        && !$past(reloc_en) && !$past(reloc_en, 2) |-> $stable(base_addr))
        else $error("base moved");
endmodule

bind ver_readout ver_readout_asserts chk_u (.core_clk, .sys_rst, .ttr_n, .mclr_n,
    .sw_clear, .reloc_en, .block_size, .geo, .bus_req, .bus_addr, .bus_am, .bus_ack,
    .bus_err, .bus_rdata, .buf_free, .store_clear, .time_tag, .evt_bytes,
    .err_latched, .base_addr);

// file: tb/ver_master_model.sv
// Purpose: bus master issuing one beat per command
// Assumes: one beat outstanding at a time
// Notes: gives up after LIMIT cycles when nobody answers
module ver_master_model #(
    parameter int LIMIT = 12
) (
    // Clock
    input wire logic core_clk,
    // Bench commands
    input wire logic go,
    input wire logic [31:0] cmd_addr,
    input wire logic [5:0] cmd_am,
    input wire logic cmd_blk,
    output logic done,
    output logic got_ack,
    output logic got_err,
    output logic [31:0] got_data,
    // Bus side
    output logic bus_req,
    output logic [31:0] bus_addr,
    output logic [5:0] bus_am,
    output logic bus_blk,
    input wire logic bus_ack,
    input wire logic bus_err,
    input wire logic [31:0] bus_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    int n;
    initial begin
        {bus_req, bus_blk, done, got_ack, got_err} = 5'h00;
        bus_addr = 32'hFFFF_FFFF;
        bus_am = 6'h3F;
        got_data = 32'h0;
        forever begin
            @(posedge core_clk);
            done <= 1'b0;
            if (go) begin
                bus_req <= 1'b1;
                bus_addr <= cmd_addr;
                bus_am <= cmd_am;
                bus_blk <= cmd_blk;
                @(posedge core_clk);
                bus_req <= 1'b0;
                for (n = 0; n < LIMIT && !(bus_ack || bus_err); n++) @(posedge core_clk);
                got_ack <= bus_ack;
                got_err <= bus_err;
                got_data <= bus_rdata;
                done <= 1'b1;
                // Released lines never keep the old address
                bus_addr <= ~cmd_addr;
                bus_am <= ~cmd_am;
            end
        end
    end
endmodule

// file: tb/ver_readout_tb.sv
// Purpose: self-checking bench for the readout slave
// Assumes: beats go through the master model
// Notes: FIFO is filled to refusal, then drained
module ver_readout_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [31:0] a;
        logic [5:0] am;
        logic ack;
        logic [31:0] d;
    } ver_tb_row_t;
    ver_pkg::ver_word_t evt_in;
    ver_pkg::ver_role_t cblt_role;
    logic core_clk, sys_rst, evt_in_valid, evt_in_ready, buf_free, store_clear, ttr_n;
    logic mclr_n, sw_clear, berr_en, even_word_padding_enable, reloc_en, bus_cyc, iack_in;
    logic bus_req, bus_blk, bus_ack, bus_err, iack_out, err_latched, go, cmd_blk, done;
    logic got_ack, got_err, tok_seen = 1'b0;
    logic [15:0] reloc_addr, block_size, rot_sw;
    logic [7:0] blt_evt_num, cblt_base;
    logic [4:0] geo;
    logic [5:0] bus_am, cmd_am, rm = 6'h39;
    logic [31:0] bus_addr, bus_rdata, time_tag, base_addr, cmd_addr, got_data;
    logic [31:0] ra = 32'h00FF_0000;
    logic [23:0] evt_cnt;
    logic [19:0] evt_bytes;
    int miscompares = 0, checked = 0, cycles = 0, frees = 0;
    ver_tb_row_t rows [7] = '{
        '{32'h0058_0000, 6'h2F, 1'b1, 32'h0000_000B},
        '{32'h0060_0000, 6'h2F, 1'b0, 32'h0},
        '{32'h00FF_0000, 6'h39, 1'b1, ver_pkg::FILLER_WORD},
        '{32'h00FF_0FFC, 6'h39, 1'b1, ver_pkg::FILLER_WORD},
        '{32'hA5FF_0800, 6'h09, 1'b1, ver_pkg::FILLER_WORD},
        '{32'h00FE_0000, 6'h39, 1'b0, 32'h0},
        '{32'h00FF_1000, 6'h39, 1'b0, 32'h0}};

    ver_readout dut_u (.core_clk, .sys_rst, .evt_in, .evt_in_valid, .evt_in_ready,
        .buf_free, .store_clear, .ttr_n, .mclr_n, .sw_clear, .berr_en,
        .even_word_padding_enable, .reloc_en, .reloc_addr, .blt_evt_num, .block_size,
        .cblt_role, .cblt_base, .rot_sw, .geo, .bus_cyc, .bus_req, .bus_addr, .bus_am,
        .bus_blk, .bus_ack, .bus_err, .bus_rdata, .iack_in, .iack_out, .time_tag,
        .evt_cnt, .evt_bytes, .err_latched, .base_addr);
    ver_master_model mst_u (.core_clk, .go, .cmd_addr, .cmd_am, .cmd_blk, .done,
        .got_ack, .got_err, .got_data, .bus_req, .bus_addr, .bus_am, .bus_blk, .bus_ack,
        .bus_err, .bus_rdata);

    // ==================================================================
    // Clock, watchdog and pulse counters
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (buf_free === 1'b1) frees <= frees + 1;
        if (iack_out === 1'b1) tok_seen <= 1'b1;
        if (cycles == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end

    // ==================================================================
    // Tasks
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic beat(input logic [31:0] a, input logic [5:0] am, input logic blk);
        int n = 0;
        cmd_addr <= a;
        cmd_am <= am;
        cmd_blk <= blk;
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
        do begin
            @(posedge core_clk);
            n++;
        end while (!done && n < 40);
    endtask
    task automatic rd(input logic [31:0] exp);
        beat(ra, rm, 1'b1);
        chk("read answer", {30'h0, got_ack, got_err}, 32'h2);
        chk("read data", got_data, exp);
    endtask
    task automatic push(input int n, input logic [31:0] d0);
        for (int i = 0; i < n; i++) begin
            evt_in <= {i == n - 1, d0 + 32'(i)};
            evt_in_valid <= 1'b1;
            do @(posedge core_clk); while (!evt_in_ready);
        end
        evt_in_valid <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic restart();
        bus_cyc <= 1'b0;
        repeat (3) @(posedge core_clk);
        bus_cyc <= 1'b1;
        repeat (2) @(posedge core_clk);
    endtask
    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ==================================================================
    // Main sequence
    initial begin
        {sys_rst, ttr_n, mclr_n, bus_cyc} = 4'hF;
        {evt_in_valid, sw_clear, berr_en, even_word_padding_enable, reloc_en} = 5'h00;
        {iack_in, go, cmd_blk} = 3'h0;
        evt_in = '0;
        reloc_addr = 16'h0000;
        blt_evt_num = 8'h00;
        block_size = 16'h0007;
        cblt_role = ver_pkg::ROLE_NONE;
        cblt_base = 8'hC0;
        rot_sw = 16'hA5FF;
        geo = 5'h0B;
        repeat (12) @(posedge core_clk);
        chk("reset bytes", {12'h0, evt_bytes}, 32'h10);
        chk("reset ready", {31'h0, evt_in_ready}, 32'h1);
        sys_rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        rot_sw <= 16'h1234;
        chk("base", base_addr, 32'hA5FF_0000);
        chk("length", {12'h0, evt_bytes}, 32'h48);
        foreach (rows[r]) begin
            beat(rows[r].a, rows[r].am, 1'b0);
            chk("row answer", {30'h0, got_ack, got_err}, {30'h0, rows[r].ack, 1'b0});
            if (rows[r].ack) chk("row data", got_data, rows[r].d);
        end
        for (int e = 0; e < 4; e++) push(4, 32'hE000_0000 + 32'(e * 16));
        @(posedge core_clk);
        chk("full", {31'h0, evt_in_ready}, 32'h0);
        for (int w = 0; w < 16; w++) rd(32'hE000_0000 + 32'((w / 4) * 16 + w % 4));
        chk("frees", 32'(frees), 32'h4);
        chk("count", {8'h0, evt_cnt}, 32'h4);
        rd(ver_pkg::FILLER_WORD);
        push(4, 32'h5000_0000);
        rd(32'h5000_0000);
        rd(32'h5000_0001);
        restart();
        rd(32'h5000_0002);
        rd(32'h5000_0003);
        berr_en <= 1'b1;
        even_word_padding_enable <= 1'b1;
        blt_evt_num <= 8'h01;
        push(3, 32'h7000_0000);
        push(3, 32'h7100_0000);
        restart();
        for (int w = 0; w < 3; w++) rd(32'h7000_0000 + 32'(w));
        rd(ver_pkg::PAD_WORD);
        beat(ra, rm, 1'b1);
        chk("block end", {30'h0, got_ack, got_err}, 32'h1);
        chk("error flag", {31'h0, err_latched}, 32'h1);
        berr_en <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            if (k == 1) push(2, 32'h8000_0000);
            restart();
            if (k == 0) mclr_n <= 1'b0;
            else sw_clear <= 1'b1;
            repeat (2) @(posedge core_clk);
            mclr_n <= 1'b1;
            sw_clear <= 1'b0;
            @(posedge core_clk);
            rd(ver_pkg::FILLER_WORD);
        end
        reloc_en <= 1'b1;
        reloc_addr <= 16'h3300;
        repeat (3) @(posedge core_clk);
        chk("relocated", base_addr, 32'h3300_0000);
        beat(32'h3300_0004, 6'h09, 1'b0);
        chk("relocated hit", {31'h0, got_ack}, 32'h1);
        reloc_addr <= 16'h0000;
        repeat (3) @(posedge core_clk);
        chk("zero relocation", base_addr, 32'hA5FF_0000);
        reloc_en <= 1'b0;
        ttr_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk("tag held", time_tag, 32'h0);
        ttr_n <= 1'b1;
        repeat (5) @(posedge core_clk);
        chk("tag runs", {31'h0, time_tag != 32'h0}, 32'h1);
        // Chain: first board hands on the token, last one ends with error
        cblt_role <= ver_pkg::ROLE_FIRST;
        berr_en <= 1'b1;
        blt_evt_num <= 8'h00;
        ra = 32'hC000_0000;
        rm = 6'h0B;
        push(2, 32'h9000_0000);
        restart();
        rd(32'h9000_0000);
        rd(32'h9000_0001);
        beat(ra, rm, 1'b1);
        chk("token passed", {30'h0, got_ack, tok_seen}, 32'h1);
        cblt_role <= ver_pkg::ROLE_LAST;
        restart();
        iack_in <= 1'b1;
        @(posedge core_clk);
        iack_in <= 1'b0;
        beat(ra, rm, 1'b1);
        chk("chain end", {30'h0, got_ack, got_err}, 32'h1);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk("error cleared", {31'h0, err_latched}, 32'h0);
        chk("count cleared", {8'h0, evt_cnt}, 32'h0);
        chk("new base", base_addr, 32'h1234_0000);
        report_and_stop();
    end
endmodule
